// ---- abd_consts.svh ----
// constants of the audio bandwidth detector
`ifndef ABD_CONSTS_SVH
`define ABD_CONSTS_SVH
// ---------------------------------------------------------------
// band table: start and stop bins, band 0 in the low six bits
// ---------------------------------------------------------------
`define ABD_BAND_START {6'h2E, 6'h2A, 6'h23, 6'h1F, 6'h1B, 6'h17, 6'h0E, 6'h0B, 6'h03}
`define ABD_BAND_STOP {6'h31, 6'h2D, 6'h26, 6'h22, 6'h1E, 6'h1A, 6'h11, 6'h0E, 6'h06}
`define ABD_BAND_W 6
`define ABD_NBANDS 9
// ---------------------------------------------------------------
// input rate codes
// ---------------------------------------------------------------
`define ABD_RATE_8K 2'h0
`define ABD_RATE_16K 2'h1
`define ABD_RATE_32K 2'h2
`define ABD_RATE_48K 2'h3
// ---------------------------------------------------------------
// log10 values, 8 fractional bits; ABD_LOG_MUL is log10(2) with 12 fractional bits
// ---------------------------------------------------------------
// log10(8 * scale^2), scale 88.293854 / 88.300926 / 88.304118 / 88.028412
`define ABD_LOGSCL_8K 16'h04CC
`define ABD_LOGSCL_16K 16'h04CC
`define ABD_LOGSCL_32K 16'h04CC
`define ABD_LOGSCL_48K 16'h04CB
`define ABD_OFFSET 18'h0019A
`define ABD_LOG_FLOOR 16'hE000
`define ABD_LOG_MUL 16'h04D1
`define ABD_NOISE_THR 16'h1E00
// ---------------------------------------------------------------
// counters and bitrates (units of 0.1 kbps)
// ---------------------------------------------------------------
`define ABD_CNT_MAX 7'h64
`define ABD_CNT_MIN 7'h00
`define ABD_BR_NB_MAX 16'h00F4
`define ABD_BR_SWB_MIN 16'h0060
`define ABD_BR_FB_MIN 16'h00A4
`endif

// ---- abd_pkg.sv ----
// types of the audio bandwidth detector
package abd_pkg;
  typedef enum logic [5:0] {
    ABD_IDLE = 6'h01,
    ABD_LOG = 6'h02,
    ABD_MEAN = 6'h04,
    ABD_TRACK = 6'h08,
    ABD_COUNT = 6'h10,
    ABD_SELECT = 6'h20
  } abd_state_t;
  typedef enum logic [1:0] {
    ABD_NARROWBAND = 2'h0,
    ABD_WIDEBAND = 2'h1,
    ABD_SUPER_WIDEBAND = 2'h2,
    ABD_FULLBAND = 2'h3
  } abd_bw_t;
  typedef struct packed {
    abd_state_t state;
    logic [3:0] idx;
    logic [8:0][33:0] acc;
    logic [8:0][15:0] lg;
    logic [3:0][17:0] mean;
    logic [3:0][17:0] maxe;
    logic [2:0][17:0] lt;
    logic [2:0][6:0] cnt;
    abd_bw_t bw;
    logic bw_valid;
    logic busy;
  } abd_st_t;
endpackage : abd_pkg

// ---- abd_log10.sv ----
// registered base-ten logarithm, 8 fractional bits
`timescale 1ns/10ps
`default_nettype none
`include "abd_consts.svh"
module abd_log10 #(
  parameter int W = 34
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // operand and result
  input wire logic [W-1:0] value_i,
  output logic [15:0] log_o
);
  logic [15:0] q;
  logic [9:0] l2;
  logic [W-1:0] sh;
  logic [25:0] prod;
  logic [5:0] msb;
  always_comb begin
    msb = 6'h00;
    for (int i = 0; i < W; i++) begin
      if (value_i[i]) begin
        msb = 6'(i);
      end
    end
    // four bits below the leading one give a linear mantissa
    sh = value_i << (W - 1 - int'(msb));
    l2 = {msb, sh[W-2 -: 4]};
    prod = 26'(l2) * 26'(`ABD_LOG_MUL);
    q = (value_i == '0) ? `ABD_LOG_FLOOR : prod[23:8];
  end
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      log_o <= 16'h0000;
    end else begin
      log_o <= q;
    end
  end
endmodule : abd_log10
`default_nettype wire

// ---- abd_detector.sv ----
// audio bandwidth detector: band energies to a per-frame bandwidth decision
// Summary of operation
// - Detect only above 8 kHz input; the mode follows the detected bandwidth.
// - Result is narrowband, wideband, super-wideband or fullband.
// - Normal mode sums four 400 Hz filterbank bins into one 1600 Hz band.
// - Nine bands with bin pairs 3-6 up to 46-49, limited by input rate.
// - Band sums become log10 after division by eight times scale squared.
// - Scale is 88.293854, 88.300926, 88.304118 or 88.028412 by rate.
// - Per-bandwidth means from bands 0, 1-2, 3-6, 7-8, plus 1.6.
// - Narrowband maximum is mean plus offset; others are group maxima plus 1.6.
// - Legacy mode works on windowed DCT bands grouped the same nine ways.
// - Legacy mode takes unscaled log10 and drops the 1.6 offset.
// - One decision path serves both modes; only thresholds differ.
// - Long-term means: 0.75 times old plus 0.25 times current.
// - Long-term update only with activity and noise above 30 dB.
// - Counter tests run in fixed order, each using earlier results.
// - Selection tests run in order; counters then forced to 0 or 100.
// - At 9.6 kbps a fullband result becomes super-wideband.
// - Bandwidth is capped to the bitrate ranges supported for it.
`timescale 1ns/10ps
`default_nettype none
`include "abd_consts.svh"
module abd_detector #(
  parameter logic signed [17:0] THR_WB = 18'h00300,
  parameter logic signed [17:0] THR_SWB = 18'h00200,
  parameter logic signed [17:0] THR_FB = 18'h00180,
  parameter logic signed [17:0] THR_LT_GAP = 18'h00100,
  parameter logic signed [17:0] THR_DCT_ADJ = 18'h00500,
  parameter logic [6:0] CNT_STEP = 7'h05,
  parameter logic [6:0] SEL_ON = 7'h5A,
  parameter logic [6:0] SEL_OFF = 7'h0A
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // energy stream from the analysis stage
  input wire logic bin_valid_i,
  input wire logic [5:0] bin_index_i,
  input wire logic [31:0] bin_energy_i,
  input wire logic frame_done_i,
  // frame configuration and side information
  input wire logic [1:0] rate_i,
  input wire logic legacy_mode_i,
  input wire logic [15:0] bitrate_i,
  input wire logic activity_decision_i,
  input wire logic [15:0] noise_lt_i,
  // decision
  output logic [1:0] detected_bandwidth_o,
  output logic bw_valid_o,
  output logic busy_o
);
  // ---------------------------------------------------------------
  // state and log unit
  // ---------------------------------------------------------------
  localparam logic [53:0] BAND_START = `ABD_BAND_START;
  localparam logic [53:0] BAND_STOP = `ABD_BAND_STOP;
  abd_pkg::abd_st_t st;
  abd_pkg::abd_st_t next_st;
  logic [33:0] log_in;
  logic [15:0] log_out;
  abd_log10 #(
    .W(34)
  ) u_log (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .value_i(log_in),
    .log_o(log_out)
  );
  assign log_in = st.acc[st.idx[3:0] < 4'h9 ? st.idx : 4'h0];
  // ---------------------------------------------------------------
  // combinational helpers
  // ---------------------------------------------------------------
  logic [8:0] band_on;
  logic [15:0] scl;
  logic signed [17:0] off;
  logic signed [17:0] adj;
  always_comb begin
    case (rate_i)
      `ABD_RATE_8K: begin
        band_on = 9'h001;
        scl = `ABD_LOGSCL_8K;
      end
      `ABD_RATE_16K: begin
        band_on = 9'h007;
        scl = `ABD_LOGSCL_16K;
      end
      `ABD_RATE_32K: begin
        band_on = 9'h07F;
        scl = `ABD_LOGSCL_32K;
      end
      default: begin
        band_on = 9'h1FF;
        scl = `ABD_LOGSCL_48K;
      end
    endcase
    off = legacy_mode_i ? 18'sh00000 : $signed(`ABD_OFFSET);
    adj = legacy_mode_i ? THR_DCT_ADJ : 18'sh00000;
  end
  function automatic logic signed [17:0] sx(input logic [15:0] v);
    sx = {{2{v[15]}}, v};
  endfunction : sx
  function automatic logic signed [17:0] mx(input logic signed [17:0] a, input logic signed [17:0] b);
    mx = (a > b) ? a : b;
  endfunction : mx
  function automatic logic [6:0] step(input logic [6:0] c, input logic up);
    if (up) begin
      step = (c > `ABD_CNT_MAX - CNT_STEP) ? `ABD_CNT_MAX : c + CNT_STEP;
    end else begin
      step = (c < CNT_STEP) ? `ABD_CNT_MIN : c - CNT_STEP;
    end
  endfunction : step
  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  logic signed [19:0] s4;
  logic signed [19:0] lt3;
  logic wb_ok;
  logic swb_ok;
  logic fb_ok;
  abd_pkg::abd_bw_t b;
  always_comb begin
    next_st = st;
    next_st.bw_valid = 1'b0;
    s4 = 20'sh00000;
    lt3 = 20'sh00000;
    wb_ok = 1'b0;
    swb_ok = 1'b0;
    fb_ok = 1'b0;
    b = st.bw;
    case (st.state)
      abd_pkg::ABD_IDLE: begin
        if (bin_valid_i) begin
          for (int i = 0; i < `ABD_NBANDS; i++) begin
            if (bin_index_i >= BAND_START[i*`ABD_BAND_W +: 6] && bin_index_i <= BAND_STOP[i*`ABD_BAND_W +: 6]) begin
              next_st.acc[i] = st.acc[i] + 34'(bin_energy_i);
            end
          end
        end
        if (frame_done_i) begin
          next_st.state = abd_pkg::ABD_LOG;
          next_st.idx = 4'h0;
          next_st.busy = 1'b1;
        end
      end
      abd_pkg::ABD_LOG: begin
        // result of the previous index leaves the log unit now
        if (st.idx != 4'h0) begin
          if (!band_on[st.idx - 4'h1]) begin
            next_st.lg[st.idx - 4'h1] = `ABD_LOG_FLOOR;
          end else if (legacy_mode_i) begin
            next_st.lg[st.idx - 4'h1] = log_out;
          end else begin
            next_st.lg[st.idx - 4'h1] = log_out - scl;
          end
        end
        next_st.idx = st.idx + 4'h1;
        if (st.idx == 4'h9) begin
          next_st.state = abd_pkg::ABD_MEAN;
        end
      end
      abd_pkg::ABD_MEAN: begin
        next_st.mean[0] = sx(st.lg[0]) + off;
        next_st.mean[1] = 18'((sx(st.lg[1]) + sx(st.lg[2])) >>> 1) + off;
        s4 = 20'(sx(st.lg[3])) + 20'(sx(st.lg[4])) + 20'(sx(st.lg[5])) + 20'(sx(st.lg[6]));
        next_st.mean[2] = 18'(s4 >>> 2) + off;
        next_st.mean[3] = 18'((sx(st.lg[7]) + sx(st.lg[8])) >>> 1) + off;
        next_st.maxe[0] = sx(st.lg[0]) + off + off;
        next_st.maxe[1] = mx(sx(st.lg[1]), sx(st.lg[2])) + off;
        next_st.maxe[2] = mx(mx(sx(st.lg[3]), sx(st.lg[4])), mx(sx(st.lg[5]), sx(st.lg[6]))) + off;
        next_st.maxe[3] = mx(sx(st.lg[7]), sx(st.lg[8])) + off;
        next_st.state = abd_pkg::ABD_TRACK;
      end
      abd_pkg::ABD_TRACK: begin
        if (activity_decision_i && noise_lt_i > `ABD_NOISE_THR) begin
          for (int i = 0; i < 3; i++) begin
            lt3 = 20'($signed(st.lt[i])) * 20'sd3 + 20'($signed(st.mean[i]));
            next_st.lt[i] = 18'(lt3 >>> 2);
          end
        end
        next_st.state = abd_pkg::ABD_COUNT;
      end
      abd_pkg::ABD_COUNT: begin
        // each test needs the one before it to have passed
        // log energies go negative for quiet bands, so every compare is signed
        wb_ok = $signed(st.maxe[1]) > THR_WB + adj && $signed(st.lt[1]) > $signed(st.lt[0]) - THR_LT_GAP;
        swb_ok = wb_ok && $signed(st.maxe[2]) > THR_SWB + adj && $signed(st.lt[2]) > $signed(st.lt[1]) - THR_LT_GAP;
        fb_ok = swb_ok && $signed(st.maxe[3]) > THR_FB + adj && $signed(st.mean[3]) > $signed(st.mean[2]) - THR_LT_GAP;
        next_st.cnt[0] = step(st.cnt[0], wb_ok);
        next_st.cnt[1] = step(st.cnt[1], swb_ok);
        next_st.cnt[2] = step(st.cnt[2], fb_ok);
        next_st.state = abd_pkg::ABD_SELECT;
      end
      abd_pkg::ABD_SELECT: begin
        if (st.cnt[0] >= SEL_ON && b == abd_pkg::ABD_NARROWBAND) begin
          b = abd_pkg::ABD_WIDEBAND;
        end
        if (st.cnt[1] >= SEL_ON && b < abd_pkg::ABD_SUPER_WIDEBAND) begin
          b = abd_pkg::ABD_SUPER_WIDEBAND;
          next_st.cnt[0] = `ABD_CNT_MAX;
        end
        if (st.cnt[2] >= SEL_ON && b < abd_pkg::ABD_FULLBAND) begin
          b = abd_pkg::ABD_FULLBAND;
          next_st.cnt[0] = `ABD_CNT_MAX;
          next_st.cnt[1] = `ABD_CNT_MAX;
        end
        if (st.cnt[2] < SEL_OFF && b == abd_pkg::ABD_FULLBAND) begin
          b = abd_pkg::ABD_SUPER_WIDEBAND;
          next_st.cnt[2] = `ABD_CNT_MIN;
        end
        if (st.cnt[1] < SEL_OFF && b >= abd_pkg::ABD_SUPER_WIDEBAND) begin
          b = abd_pkg::ABD_WIDEBAND;
          next_st.cnt[1] = `ABD_CNT_MIN;
          next_st.cnt[2] = `ABD_CNT_MIN;
        end
        if (st.cnt[0] < SEL_OFF && b >= abd_pkg::ABD_WIDEBAND) begin
          b = abd_pkg::ABD_NARROWBAND;
          next_st.cnt = '0;
        end
        // the input rate bounds what can be present at all
        if (rate_i == `ABD_RATE_8K) begin
          b = abd_pkg::ABD_NARROWBAND;
        end else if (rate_i == `ABD_RATE_16K && b > abd_pkg::ABD_WIDEBAND) begin
          b = abd_pkg::ABD_WIDEBAND;
        end else if (rate_i == `ABD_RATE_32K && b == abd_pkg::ABD_FULLBAND) begin
          b = abd_pkg::ABD_SUPER_WIDEBAND;
        end
        if (b == abd_pkg::ABD_FULLBAND && bitrate_i < `ABD_BR_FB_MIN) begin
          b = abd_pkg::ABD_SUPER_WIDEBAND;
        end
        if (b == abd_pkg::ABD_SUPER_WIDEBAND && bitrate_i < `ABD_BR_SWB_MIN) begin
          b = abd_pkg::ABD_WIDEBAND;
        end
        if (b == abd_pkg::ABD_NARROWBAND && bitrate_i > `ABD_BR_NB_MAX && rate_i != `ABD_RATE_8K) begin
          b = abd_pkg::ABD_WIDEBAND;
        end
        next_st.bw = b;
        next_st.bw_valid = 1'b1;
        next_st.busy = 1'b0;
        next_st.acc = '0;
        next_st.state = abd_pkg::ABD_IDLE;
      end
      default: begin
        next_st.state = abd_pkg::ABD_IDLE;
        next_st.busy = 1'b0;
      end
    endcase
  end
  // ---------------------------------------------------------------
  // state register and outputs
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st <= '{state: abd_pkg::ABD_IDLE, bw: abd_pkg::ABD_NARROWBAND, default: '0};
    end else begin
      st <= next_st;
    end
  end
  assign detected_bandwidth_o = st.bw;
  assign bw_valid_o = st.bw_valid;
  assign busy_o = st.busy;
  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  sequence s_frame_go;
    st.state == abd_pkg::ABD_IDLE && frame_done_i;
  endsequence
  sequence s_decided;
    bw_valid_o && !busy_o;
  endsequence
  a_one_decision: assert property (s_frame_go |-> ##15 s_decided)
    else $error("decision not made fifteen cycles after frame end");
  a_busy_span: assert property (s_frame_go |=> busy_o [*8] ##6 busy_o)
    else $error("busy dropped during frame processing");
  a_fb_cap: assert property (bw_valid_o && $past(bitrate_i) < `ABD_BR_FB_MIN |-> detected_bandwidth_o != 2'h3)
    else $error("fullband reported below its bitrate range");
  a_swb_cap: assert property (bw_valid_o && $past(bitrate_i) < `ABD_BR_SWB_MIN |-> detected_bandwidth_o < 2'h2)
    else $error("super-wideband reported below its bitrate range");
  a_rate_low: assert property (bw_valid_o && $past(rate_i) == `ABD_RATE_8K |-> detected_bandwidth_o == 2'h0)
    else $error("bandwidth detected at 8 kHz input");
  a_cnt_range: assert property (st.cnt[0] <= 7'h64 && st.cnt[1] <= 7'h64 && st.cnt[2] <= 7'h64)
    else $error("bandwidth counter out of range");
  a_lt_hold: assert property (st.state == abd_pkg::ABD_TRACK &&
    !(activity_decision_i && noise_lt_i > `ABD_NOISE_THR) |=> $stable(st.lt))
    else $error("long-term mean moved without activity and noise above 30 dB");
  a_nb_max: assert property (st.state == abd_pkg::ABD_MEAN && !legacy_mode_i |=> st.maxe[0] == st.mean[0] + 18'sh0019A)
    else $error("narrowband maximum not mean plus offset");
  a_dct_mean: assert property (st.state == abd_pkg::ABD_MEAN && legacy_mode_i |=> st.mean[0] == sx(st.lg[0]))
    else $error("offset applied in legacy mode");
endmodule : abd_detector
`default_nettype wire

// ---- abd_energy_source.sv ----
// upstream energy source model that feeds bin energies to the detector
`timescale 1ns/10ps
`default_nettype none
module abd_energy_source (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // control from the bench
  input wire logic start_i,
  input wire logic [31:0] level_i,
  // bin stream to the detector
  output var logic bin_valid_o,
  output var logic [5:0] bin_index_o,
  output var logic [31:0] bin_energy_o,
  output var logic frame_done_o
);
  // ---------------------------------------------------------------
  // frame streaming
  // ---------------------------------------------------------------
  initial begin
    bin_valid_o = 1'b0;
    bin_index_o = 6'h00;
    bin_energy_o = 32'h00000000;
    frame_done_o = 1'b0;
    forever begin
      @(posedge sys_clk_i);
      if (rst_n_i && start_i) begin
        // every bin of bands 0 to 8, back to back, done with the last bin
        for (int k = 3; k <= 49; k++) begin
          #1;
          bin_valid_o = 1'b1;
          bin_index_o = 6'(k);
          bin_energy_o = level_i;
          frame_done_o = (k == 49);
          @(posedge sys_clk_i);
        end
        #1;
        bin_valid_o = 1'b0;
        frame_done_o = 1'b0;
        // released lines show the inverse of their last value
        bin_index_o = ~bin_index_o;
        bin_energy_o = ~bin_energy_o;
      end
    end
  end
endmodule : abd_energy_source
`default_nettype wire

// ---- abd_detector_tb.sv ----
// self-checking bench for the audio bandwidth detector
`timescale 1ns/10ps
`default_nettype none
module abd_detector_tb;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  localparam logic [31:0] MID = 32'h002625A0;
  logic sys_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic start = 1'b0;
  logic [31:0] level = 32'h00000000;
  logic bin_valid;
  logic [5:0] bin_index;
  logic [31:0] bin_energy;
  logic frame_done;
  logic [1:0] rate = 2'h3;
  logic legacy = 1'b0;
  logic [15:0] bitrate = 16'h0500;
  logic activity = 1'b1;
  logic [15:0] noise = 16'h2000;
  logic [1:0] bw;
  logic bw_valid;
  logic busy;
  int n_errors = 0;
  int comparisons = 0;

  always #10 sys_clk_i = ~sys_clk_i;

  abd_energy_source u_abd_energy_source (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .start_i(start), .level_i(level),
    .bin_valid_o(bin_valid), .bin_index_o(bin_index), .bin_energy_o(bin_energy), .frame_done_o(frame_done)
  );

  abd_detector u_abd_detector (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .bin_valid_i(bin_valid), .bin_index_i(bin_index),
    .bin_energy_i(bin_energy), .frame_done_i(frame_done), .rate_i(rate), .legacy_mode_i(legacy),
    .bitrate_i(bitrate), .activity_decision_i(activity), .noise_lt_i(noise),
    .detected_bandwidth_o(bw), .bw_valid_o(bw_valid), .busy_o(busy)
  );

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [1:0] got, input logic [1:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // one frame at a given bin level; checks the busy window, the pulse and the decision
  task automatic run_frame(input logic [31:0] e, input logic [1:0] exp);
    int n;
    n = 0;
    @(posedge sys_clk_i);
    #1 level = e;
    start = 1'b1;
    @(posedge sys_clk_i);
    #1 start = 1'b0;
    do begin
      @(posedge sys_clk_i);
      n++;
    end while (frame_done !== 1'b1 && n < 200);
    if (n >= 200) begin
      n_errors++;
      report_and_stop();
    end
    // the value shown just after edge c is what edge c+1 samples
    for (int c = 1; c <= 15; c++) begin
      @(posedge sys_clk_i);
      #1;
      chk({1'b0, busy}, {1'b0, c < 14});
      chk({1'b0, bw_valid}, {1'b0, c == 14});
    end
    chk(bw, exp);
  endtask : run_frame

  // counters climb by one step a frame; selection fires at the eighteenth frame
  // narrowband is lifted to wideband at this bitrate
  task automatic climb();
    for (int f = 1; f <= 20; f++) begin
      run_frame(MID, f < 18 ? abd_pkg::ABD_WIDEBAND : abd_pkg::ABD_FULLBAND);
    end
  endtask : climb

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic test_reset();
    chk({1'b0, busy}, 2'h0);
    chk({1'b0, bw_valid}, 2'h0);
    chk(bw, abd_pkg::ABD_NARROWBAND);
    $display("test_reset finished");
  endtask : test_reset

  task automatic test_climb();
    climb();
    $display("test_climb finished");
  endtask : test_climb

  task automatic test_legacy_fall();
    legacy = 1'b1;
    for (int f = 1; f <= 19; f++) begin
      run_frame(MID, f < 19 ? abd_pkg::ABD_FULLBAND : abd_pkg::ABD_WIDEBAND);
    end
    legacy = 1'b0;
    $display("test_legacy_fall finished");
  endtask : test_legacy_fall

  task automatic test_narrow_cap();
    bitrate = 16'h0140;
    activity = 1'b0;
    run_frame(32'h00000000, abd_pkg::ABD_WIDEBAND);
    bitrate = 16'h00F4;
    activity = 1'b1;
    noise = 16'h1E00;
    run_frame(32'h00000000, abd_pkg::ABD_NARROWBAND);
    noise = 16'h2000;
    $display("test_narrow_cap finished");
  endtask : test_narrow_cap

  task automatic test_caps();
    bitrate = 16'h0500;
    climb();
    bitrate = 16'h0060;
    run_frame(MID, abd_pkg::ABD_SUPER_WIDEBAND);
    bitrate = 16'h0064;
    run_frame(MID, abd_pkg::ABD_SUPER_WIDEBAND);
    bitrate = 16'h005F;
    run_frame(MID, abd_pkg::ABD_WIDEBAND);
    bitrate = 16'h0500;
    rate = 2'h2;
    run_frame(MID, abd_pkg::ABD_SUPER_WIDEBAND);
    rate = 2'h1;
    run_frame(MID, abd_pkg::ABD_WIDEBAND);
    rate = 2'h0;
    run_frame(MID, abd_pkg::ABD_NARROWBAND);
    $display("test_caps finished");
  endtask : test_caps

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (6) @(posedge sys_clk_i);
    #1;
    test_reset();
    repeat (6) @(posedge sys_clk_i);
    #1 rst_n_i = 1'b1;
    test_climb();
    test_legacy_fall();
    test_narrow_cap();
    test_caps();
    report_and_stop();
  end
endmodule : abd_detector_tb
`default_nettype wire
